// ---- logic/bmad_pkg.sv ----
// address map, target numbering and master numbering for the bus matrix decoder
// assumes one system clock and the system reset; no software-visible registers
package bmad_pkg;
  // master-side port numbers
  localparam logic [2:0]  MST_DMA_A     = 3'h0; // micro_dma_unit A
  localparam logic [2:0]  MST_DMA_B     = 3'h1; // micro_dma_unit B
  localparam logic [2:0]  MST_DMA_C     = 3'h2; // micro_dma_unit C
  localparam logic [2:0]  MST_SBUS      = 3'h3; // core system bus
  localparam logic [2:0]  MST_DBUS      = 3'h4; // core data bus
  localparam logic [2:0]  MST_IBUS      = 3'h5; // core instruction bus
  // target-side port numbers
  localparam logic [3:0]  TGT_FLASH_I   = 4'h0; // flash via instruction bus
  localparam logic [3:0]  TGT_FLASH_D   = 4'h1; // flash via data bus
  localparam logic [3:0]  TGT_FLASH_MIR = 4'h2; // flash mirror
  localparam logic [3:0]  TGT_RAM0      = 4'h3; // main ram bank 0 and its mirror
  localparam logic [3:0]  TGT_RAM1      = 4'h4;
  localparam logic [3:0]  TGT_RAM2      = 4'h5;
  localparam logic [3:0]  TGT_RAM3      = 4'h6;
  localparam logic [3:0]  TGT_RAM4      = 4'h7;
  localparam logic [3:0]  TGT_BKUP_RAM  = 4'h8; // backup ram
  localparam logic [3:0]  TGT_BOOT_ROM  = 4'h9;
  localparam logic [3:0]  TGT_EXT_BUS   = 4'hA; // external bus space
  localparam logic [3:0]  TGT_PERI_A    = 4'hB; // serial, dma, adc register group
  localparam logic [3:0]  TGT_EXT_CTRL  = 4'hC; // external_bus_controller regs
  localparam logic [3:0]  TGT_NAND_ECC  = 4'hD; // nand_flash_controller correction
  localparam logic [3:0]  TGT_PERI_C    = 4'hE; // nand data, crypto, arithmetic group
  localparam logic [3:0]  TGT_PERI_D    = 4'hF; // ports, timers, flash controller
  // region boundaries, each an inclusive base or exclusive end
  localparam logic [31:0] FLASH_END     = 32'h0010_0000;
  localparam logic [31:0] BROM_END      = 32'h0000_1000;
  localparam logic [31:0] MIR_BASE      = 32'h1000_0000;
  localparam logic [31:0] MIR_END       = 32'h1004_0000;
  localparam logic [31:0] RAM0_BASE     = 32'h2000_0000;
  localparam logic [31:0] RAM1_BASE     = 32'h2004_0000;
  localparam logic [31:0] RAM2_BASE     = 32'h2004_4000;
  localparam logic [31:0] RAM3_BASE     = 32'h2004_8000;
  localparam logic [31:0] RAM4_BASE     = 32'h2004_C000;
  localparam logic [31:0] BKUP_BASE     = 32'h2008_0000;
  localparam logic [31:0] RAM_END       = 32'h2008_0800;
  localparam logic [31:0] SBB_BASE      = 32'h2200_0000;
  localparam logic [31:0] SBB_END       = 32'h2301_0000;
  localparam logic [31:0] RSV_BASE      = 32'h3F7F_F000;
  localparam logic [31:0] RSV_END       = 32'h3F80_0000;
  localparam logic [31:0] PERI_A_BASE   = 32'h4004_0000;
  localparam logic [31:0] EXT_CTRL_BASE = 32'h4005_C000;
  localparam logic [31:0] NAND_ECC_BASE = 32'h4005_C800;
  localparam logic [31:0] PERI_C_BASE   = 32'h4005_CC00;
  localparam logic [31:0] PERI_D_BASE   = 32'h400C_0000;
  localparam logic [31:0] PERI_D_END    = 32'h4010_0000;
  localparam logic [31:0] PBB_BASE      = 32'h4280_0000;
  localparam logic [31:0] PBB_END       = 32'h4400_0000;
  localparam logic [31:0] FCTL_BASE     = 32'h5DFF_0000;
  localparam logic [31:0] FMIR_BASE     = 32'h5E00_0000;
  localparam logic [31:0] FMIR_END      = 32'h5E10_0000;
  localparam logic [31:0] EXT_BASE      = 32'h6000_0000;
  localparam logic [31:0] EXT_END       = 32'h6400_0000;
  // reset values
  localparam logic        BOOT_RST      = 1'b0; // single chip map until sampled
endpackage : bmad_pkg

// ---- logic/bmad_matrix.sv ----
// six-master, sixteen-target address decoder and fixed-priority arbiter
// every request is decoded against the map chosen by the boot strap and answered with
// either a grant (plus a one-cycle select on the target side) or a bus error
// assumes masters hold req and addr until they see a grant or error pulse,
// and drop req in the cycle that pulse is shown
// assumes one system clock; all inputs are synchronous to it
// limitation: one answer per master per two cycles, since a just-answered master is masked
module bmad_matrix
  import bmad_pkg::*;
#(
  parameter int NM = 6,  // master-side ports
  parameter int NT = 16, // target-side ports
  parameter int AW = 32  // address width
)(
  input  wire  logic             clk_in,
  input  wire  logic             rst_n_in,
  input  wire  logic             boot_mode_in,   // 1 = single boot map
  input  wire  logic [NM-1:0]    m_req_in,       // per-master request level
  input  wire  logic [NM*AW-1:0] m_addr_in,      // master m at [m*AW +: AW]
  output logic       [NM-1:0]    m_gnt_out,      // one-cycle grant pulse
  output logic       [NM-1:0]    m_err_out,      // one-cycle bus error pulse
  output logic       [NT-1:0]    t_req_out,      // one-cycle target select pulse
  output logic       [NT*AW-1:0] t_addr_out,     // address to target t
  output logic       [NT*3-1:0]  t_mst_out,      // winning master number
  output logic                   boot_mode_out   // map in force
);
  import bmad_pkg::*;

  logic              boot_ff;      // held map choice
  logic              smp_done_ff;  // strap has been taken since reset
  logic [NM-1:0]     gnt_ff;       // grant pulses shown to the masters
  logic [NM-1:0]     err_ff;       // bus error pulses shown to the masters
  logic [NT-1:0]     treq_ff;      // target select pulses
  logic [NT*AW-1:0]  taddr_ff;     // last routed address per target
  logic [NT*3-1:0]   tmst_ff;      // last winning master per target
  logic [NM-1:0]     nxt_gnt;      // next grant pulses
  logic [NM-1:0]     nxt_err;      // next error pulses
  logic [NT-1:0]     nxt_treq;     // next target selects
  logic [NT*AW-1:0]  nxt_taddr;    // next routed addresses
  logic [NT*3-1:0]   nxt_tmst;     // next winning masters
  logic [NM-1:0]     live;         // requests eligible this cycle

  // true when a lies in [lo, hi); every region test except the low flash and boot rom windows and the ram bank splits goes through here so that
  // all bounds read the same way: base inclusive, end exclusive
  function automatic logic bmad_in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a < hi);
  endfunction : bmad_in_range

  // returns {hit, target}; a miss means the access is answered with an error
  // no two regions overlap, so the order of the branches only eases reading;
  // the strap-dependent low area comes first because it shadows nothing else
  function automatic logic [4:0] bmad_decode(input logic [31:0] a, input logic [2:0] m, input logic boot);
    logic       dma; // one of the three micro_dma_unit ports
    logic       sb;  // core system bus
    logic       cb;  // core data or instruction bus
    logic [4:0] r;   // {hit, target}
    dma = (m <= MST_DMA_C);
    sb  = (m == MST_SBUS);
    cb  = (m == MST_DBUS) || (m == MST_IBUS);
    r   = 5'h00;
    if (!boot && a < FLASH_END)
    begin
      // flash splits by core bus so fetches and data reads never collide
      if (cb)
      begin
        r = {1'b1, (m == MST_IBUS) ? TGT_FLASH_I : TGT_FLASH_D};
      end
    end
    else if (boot && a < BROM_END)
    begin
      // boot rom replaces flash at the bottom; the rest of the low area misses
      if (cb)
      begin
        r = {1'b1, TGT_BOOT_ROM};
      end
    end
    else if (bmad_in_range(a, MIR_BASE, MIR_END))
    begin
      // mirror lands on the same bank port as the primary range
      if (cb)
      begin
        r = {1'b1, TGT_RAM0};
      end
    end
    else if (bmad_in_range(a, RAM0_BASE, RAM_END))
    begin
      // main banks and backup ram; the core data and instruction buses miss here
      if (dma || sb)
      begin
        if (a < RAM1_BASE)
        begin
          r = {1'b1, TGT_RAM0};
        end
        else if (a < RAM2_BASE)
        begin
          r = {1'b1, TGT_RAM1};
        end
        else if (a < RAM3_BASE)
        begin
          r = {1'b1, TGT_RAM2};
        end
        else if (a < RAM4_BASE)
        begin
          r = {1'b1, TGT_RAM3};
        end
        else if (a < BKUP_BASE)
        begin
          r = {1'b1, TGT_RAM4};
        end
        else
        begin
          r = {1'b1, TGT_BKUP_RAM};
        end
      end
    end
    else if (bmad_in_range(a, SBB_BASE, SBB_END))
    begin
      // sram bit-band alias: system bus only; routed to the bank 0 port as a fixed choice
      if (sb)
      begin
        r = {1'b1, TGT_RAM0};
      end
    end
    else if (boot && bmad_in_range(a, RSV_BASE, RSV_END))
    begin
      // reserved window: contents undefined, so masters are expected to stay out
      if (sb)
      begin
        r = {1'b1, TGT_BOOT_ROM};
      end
    end
    else if (bmad_in_range(a, PERI_A_BASE, EXT_CTRL_BASE))
    begin
      // serial, dma and converter register group: every dma unit and the system bus
      if (dma || sb)
      begin
        r = {1'b1, TGT_PERI_A};
      end
    end
    else if (bmad_in_range(a, EXT_CTRL_BASE, NAND_ECC_BASE))
    begin
      // external_bus_controller registers and nand interface: dma unit A and system bus
      if (m == MST_DMA_A || sb)
      begin
        r = {1'b1, TGT_EXT_CTRL};
      end
    end
    else if (bmad_in_range(a, NAND_ECC_BASE, PERI_C_BASE))
    begin
      // nand_flash_controller correction registers: dma unit B and system bus
      if (m == MST_DMA_B || sb)
      begin
        r = {1'b1, TGT_NAND_ECC};
      end
    end
    else if (bmad_in_range(a, PERI_C_BASE, PERI_D_BASE))
    begin
      // nand data, dma_request_control, entropy_seed_unit and friends: dma unit C and system bus
      if (m == MST_DMA_C || sb)
      begin
        r = {1'b1, TGT_PERI_C};
      end
    end
    else if (bmad_in_range(a, PERI_D_BASE, PERI_D_END) || bmad_in_range(a, FCTL_BASE, FMIR_BASE))
    begin
      // ports, timers and watchdog group plus the flash controller block share port 15
      if (dma || sb)
      begin
        r = {1'b1, TGT_PERI_D};
      end
    end
    else if (bmad_in_range(a, PBB_BASE, PBB_END))
    begin
      // peripheral bit-band alias: system bus only, routed to the port 11 group
      if (sb)
      begin
        r = {1'b1, TGT_PERI_A};
      end
    end
    else if (bmad_in_range(a, FMIR_BASE, FMIR_END))
    begin
      // flash mirror: same array as the low flash window, on a port of its own
      if (m == MST_DMA_A || sb)
      begin
        r = {1'b1, TGT_FLASH_MIR};
      end
    end
    else if (bmad_in_range(a, EXT_BASE, EXT_END))
    begin
      // external bus space; at and above its end everything misses
      if (dma || sb)
      begin
        r = {1'b1, TGT_EXT_BUS};
      end
    end
    // everything else, including 0x4000_0000 below the first group, misses
    return r;
  endfunction : bmad_decode

  // strap capture: taken on the first edge after reset release, then frozen
  // a strap that moves later is ignored until the next reset, so the map never shifts mid-run
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      boot_ff     <= BOOT_RST;
      smp_done_ff <= 1'b0;
    end
    else if (!smp_done_ff)
    begin
      boot_ff     <= boot_mode_in;
      smp_done_ff <= 1'b1;
    end
  end

  // eligible requests: strap held, request up, and no answer showing this cycle;
  // a master that was just answered is masked while it drops req, so one request is served once
  always_comb
  begin
    live = '0;
    if (smp_done_ff)
    begin
      live = m_req_in & ~gnt_ff & ~err_ff;
    end
  end

  // decode and arbitrate; requests wait one cycle until the strap is held
  // a loser simply sees nothing this cycle and is tried again on the next edge,
  // which keeps the arbiter free of any per-target state
  always_comb
  begin
    logic [4:0] d;
    logic [2:0] mi;
    d         = 5'h00;
    mi        = 3'h0;
    nxt_gnt   = '0;
    nxt_err   = '0;
    nxt_treq  = '0;
    nxt_taddr = taddr_ff;
    nxt_tmst  = tmst_ff;
    // walking down from the top lets the lowest master overwrite the winner
    for (int m = NM - 1; m >= 0; m--)
    begin
      mi = 3'(m);
      d  = bmad_decode(m_addr_in[m*AW +: AW], mi, boot_ff);
      if (live[m])
      begin
        if (!d[4])
        begin
          nxt_err[m] = 1'b1;
        end
        else
        begin
          // clear the earlier (higher-numbered) winner of this target
          for (int k = 0; k < NM; k++)
          begin
            if (k > m && nxt_gnt[k] && bmad_decode(m_addr_in[k*AW +: AW], 3'(k), boot_ff) == d)
            begin
              nxt_gnt[k] = 1'b0;
            end
          end
          nxt_gnt[m]                = 1'b1;
          nxt_treq[d[3:0]]          = 1'b1;
          nxt_taddr[d[3:0]*AW +: AW] = m_addr_in[m*AW +: AW];
          nxt_tmst[d[3:0]*3 +: 3]   = mi;
        end
      end
    end
  end

  // master-side answers
  // both vectors are pulses: rebuilt from scratch every cycle, never held
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gnt_ff <= '0;
      err_ff <= '0;
    end
    else
    begin
      gnt_ff <= nxt_gnt;
      err_ff <= nxt_err;
    end
  end

  // target-side selects and routed addresses
  // address and master number hold between grants so a target may read them late
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      treq_ff  <= '0;
      taddr_ff <= '0;
      tmst_ff  <= '0;
    end
    else
    begin
      treq_ff  <= nxt_treq;
      taddr_ff <= nxt_taddr;
      tmst_ff  <= nxt_tmst;
    end
  end

  // every output is a flop with no logic behind it, which keeps output timing
  // independent of how deep the decode grows
  assign m_gnt_out     = gnt_ff;
  assign m_err_out     = err_ff;
  assign t_req_out     = treq_ff;
  assign t_addr_out    = taddr_ff;
  assign t_mst_out     = tmst_ff;
  assign boot_mode_out = boot_ff;
endmodule : bmad_matrix

// ---- tb/bmad_assertions.sv ----
// checker for the bus matrix decoder, watching only its ports
// assumes masters hold request and address until answered
module bmad_assertions
  import bmad_pkg::*;
#(
  parameter int NM = 6,
  parameter int NT = 16,
  parameter int AW = 32
)(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             boot_mode_in,
  input  wire logic [NM-1:0]    m_req_in,
  input  wire logic [NM*AW-1:0] m_addr_in,
  input  wire logic [NM-1:0]    m_gnt_out,
  input  wire logic [NM-1:0]    m_err_out,
  input  wire logic [NT-1:0]    t_req_out,
  input  wire logic [NT*AW-1:0] t_addr_out,
  input  wire logic [NT*3-1:0]  t_mst_out,
  input  wire logic             boot_mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [NM-1:0] fresh;   // request still waiting
  logic          seen_ff; // strap already sampled
  logic [31:0]   a0, a1, a3, a4;
  assign fresh = m_req_in & ~m_gnt_out & ~m_err_out;
  assign a0 = m_addr_in[31:0];
  assign a1 = m_addr_in[63:32];
  assign a3 = m_addr_in[127:96];
  assign a4 = m_addr_in[159:128];
  // requests in the strap cycle are ignored, so gate on this
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) seen_ff <= 1'b0;
    else seen_ff <= 1'b1;
  a_answer_cause: assert property (((m_gnt_out | m_err_out) & ~$past(m_req_in)) == '0)
    else $error("answer without request");
  a_gnt_err_excl: assert property ((m_gnt_out & m_err_out) == '0)
    else $error("grant and error together");
  a_tgt_count: assert property ($countones(t_req_out) == $countones(m_gnt_out))
    else $error("target selects differ from grants");
  a_dma_flash_flt: assert property (seen_ff && fresh[0] && a0 < FLASH_END |=> m_err_out[0])
    else $error("dma low access not faulted");
  a_dbus_flash_ok: assert property (seen_ff && fresh[4] && !boot_mode_out && a4 < FLASH_END
    |=> m_gnt_out[4] && t_req_out[1]) else $error("data bus flash not on port 1");
  a_boot_rom_port: assert property (seen_ff && fresh[4] && boot_mode_out && a4 < BROM_END
    |=> t_req_out[9]) else $error("boot rom not on port 9");
  a_dbus_ram_flt: assert property (seen_ff && fresh[4] && a4 >= RAM0_BASE && a4 < RAM_END
    |=> m_err_out[4]) else $error("data bus ram access not faulted");
  a_sbus_alias_ok: assert property (seen_ff && fresh[3] && a3 >= SBB_BASE && a3 < SBB_END
    |=> !m_err_out[3]) else $error("system bus alias faulted");
  a_low_wins: assert property (seen_ff && fresh[0] && fresh[1] && a0 >= RAM0_BASE && a0 < RAM1_BASE
    && a1 >= RAM0_BASE && a1 < RAM1_BASE |=> m_gnt_out[0] && !m_gnt_out[1] && t_mst_out[11:9] == MST_DMA_A)
    else $error("lower master lost");
  a_boot_held: assert property (seen_ff |=> $stable(boot_mode_out))
    else $error("map select moved");
  a_tgt_route: assert property (seen_ff && fresh[3] && a3 >= PERI_A_BASE && a3 < EXT_CTRL_BASE
    |=> !m_gnt_out[3] || (t_req_out[11] && t_addr_out[383:352] == $past(a3) && t_mst_out[35:33] == MST_SBUS))
    else $error("system bus access not routed to port 11");
  a_mirror_bank: assert property (seen_ff && fresh[4] && a4 >= MIR_BASE && a4 < MIR_END
    |=> !m_err_out[4] && (!m_gnt_out[4] || t_req_out[3])) else $error("data bus mirror not on bank 0 port");
endmodule : bmad_assertions
bind bmad_matrix bmad_assertions #(.NM(NM), .NT(NT), .AW(AW)) u_chk (.*);

// ---- tb/bmad_master_model.sv ----
// one bus master: raises a request on go, holds it until answered
// assumes go is a one-cycle pulse given only while idle
module bmad_master_model (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [31:0] addr_in,
  input  wire logic        gnt_in,
  input  wire logic        err_in,
  output logic             req_out,
  output logic [31:0]      addr_out,
  output logic             err_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req_out = 1'b0;
    addr_out = 32'h0;
    err_seen_out = 1'b0;
  end
  // released address is inverted so a stale value never looks valid
  always @(negedge clk_in)
    if (!req_out && go_in)
    begin
      req_out <= 1'b1;
      addr_out <= addr_in;
    end
    else if (req_out && (gnt_in || err_in))
    begin
      req_out <= 1'b0;
      addr_out <= ~addr_out;
      err_seen_out <= err_in;
    end
endmodule : bmad_master_model

// ---- tb/testbench.sv ----
// self-checking bench: six master models against the decoder
// assumes the checker is bound beside the decoder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bmad_pkg::*;
  logic         clk_in, rst_n_in, boot_mode_in, boot_out, cur_boot;
  logic [5:0]   m_req, m_gnt, m_err, go, err_seen;
  logic [191:0] m_addr;
  logic [31:0]  a_set [6];
  int           n_fail, checks;
  // region edges; the reserved window is never addressed
  logic [31:0]  corner [22] = '{32'h0, BROM_END, FLASH_END, MIR_BASE, MIR_END, RAM0_BASE, RAM4_BASE,
    BKUP_BASE, RAM_END, SBB_BASE, SBB_END, 32'h4000_0000, PERI_A_BASE, EXT_CTRL_BASE, NAND_ECC_BASE,
    PERI_C_BASE, PERI_D_BASE, PBB_BASE, FCTL_BASE, FMIR_BASE, EXT_BASE, EXT_END};
  bmad_matrix DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .boot_mode_in(boot_mode_in), .m_req_in(m_req),
    .m_addr_in(m_addr), .m_gnt_out(m_gnt), .m_err_out(m_err), .t_req_out(), .t_addr_out(),
    .t_mst_out(), .boot_mode_out(boot_out));
  for (genvar m = 0; m < 6; m++)
  begin : g_mst
    bmad_master_model u_m (.clk_in(clk_in), .go_in(go[m]), .addr_in(a_set[m]), .gnt_in(m_gnt[m]),
      .err_in(m_err[m]), .req_out(m_req[m]), .addr_out(m_addr[m*32+:32]), .err_seen_out(err_seen[m]));
  end
  // legal access per master and map
  function automatic logic ok(input int m, input logic [31:0] a, input logic b);
    logic s, c;
    s = (m == 3);
    c = (m > 3);
    if (a < (b ? BROM_END : FLASH_END)) return c;
    if (a >= MIR_BASE && a < MIR_END) return c;
    if (a >= RAM0_BASE && a < RAM_END) return !c;
    if (a >= SBB_BASE && a < SBB_END) return s;
    if (a >= PERI_A_BASE && a < EXT_CTRL_BASE) return !c;
    if (a >= EXT_CTRL_BASE && a < NAND_ECC_BASE) return m == 0 || s;
    if (a >= NAND_ECC_BASE && a < PERI_C_BASE) return m == 1 || s;
    if (a >= PERI_C_BASE && a < PERI_D_BASE) return m == 2 || s;
    if (a >= PERI_D_BASE && a < PERI_D_END) return !c;
    if (a >= PBB_BASE && a < PBB_END) return s;
    if (a >= FCTL_BASE && a < FMIR_BASE) return !c;
    if (a >= FMIR_BASE && a < FMIR_END) return m == 0 || s;
    if (a >= EXT_BASE && a < EXT_END) return !c;
    return 1'b0;
  endfunction : ok
  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %b expected %b", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // strap moves after sampling to show it is held
  task automatic do_reset(input logic b);
    rst_n_in = 1'b0;
    boot_mode_in = b;
    cur_boot = b;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    boot_mode_in = ~b;
    chk(boot_out, b);
  endtask : do_reset
  // launch masked masters together, wait for all answers
  task automatic run(input logic [5:0] mask);
    int n;
    go <= mask;
    @(negedge clk_in);
    go <= '0;
    @(negedge clk_in);
    n = 0;
    while (|m_req && n < 50)
    begin
      @(negedge clk_in);
      n++;
    end
    chk(n < 50, 1'b1);
    for (int m = 0; m < 6; m++)
      if (mask[m]) chk(err_seen[m], !ok(m, a_set[m], cur_boot));
  endtask : run
  task automatic sweep();
    for (int i = 0; i < 22; i++)
    begin
      for (int m = 0; m < 6; m++) a_set[m] <= corner[i];
      run(6'h3F);
    end
  endtask : sweep
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    #(50000 * 10);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    go = '0;
    a_set = '{default: '0};
    void'($urandom(92));
    do_reset(1'b0);
    sweep();
    repeat (200)
    begin
      for (int m = 0; m < 6; m++) a_set[m] <= corner[$urandom_range(21)];
      run(6'($urandom));
    end
    do_reset(1'b1);
    sweep();
    print_verdict();
  end
endmodule : testbench
